//--- logic/mbf_pkg.sv
package mbf_pkg;
  // ------------------------------------------------------------
  // Function and exception codes
  // ------------------------------------------------------------
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_ONE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WR_MULTI = 8'h10;
  localparam logic [7:0] FC_RW_MULTI = 8'h17;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [15:0] DIAG_ECHO = 16'h0000;
  localparam logic [15:0] DIAG_REG = 16'h0002;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  // ------------------------------------------------------------
  // Limits and telegram layout
  // ------------------------------------------------------------
  localparam logic [15:0] MAX_RD = 16'h007D;
  localparam logic [15:0] MAX_WR = 16'h0078;
  localparam logic [15:0] MAX_RW = 16'h0076;
  localparam logic [7:0] HDR_PLAIN = 8'h04;
  localparam logic [7:0] HDR_WR_MULTI = 8'h05;
  localparam logic [7:0] HDR_RW = 8'h09;
  localparam logic [7:0] LEN_EXC = 8'h03;
  localparam logic [7:0] LEN_ECHO = 8'h06;
  localparam logic [7:0] LEN_RD_HEAD = 8'h03;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_KHZ = 10000;
  localparam int RESP_MIN_US = 3000;
  localparam int RESP_MAX_US = 5000;
  localparam int RESP_CYCLES = (RESP_MIN_US * CLK_KHZ + 999) / 1000;
  localparam int TIMEOUT_CYCLES = RESP_MAX_US * CLK_KHZ / 1000;

  // Header bytes after the function code; zero for unknown codes
  function automatic logic [7:0] hdr_len(input logic [7:0] fc);
    logic [7:0] n;
    n = 8'h00;
    case (fc)
      FC_RD_HOLD, FC_RD_INPUT, FC_WR_ONE, FC_DIAG: n = HDR_PLAIN;
      FC_WR_MULTI: n = HDR_WR_MULTI;
      FC_RW_MULTI: n = HDR_RW;
      default: n = 8'h00;
    endcase
    return n;
  endfunction
endpackage

//--- logic/mbf_link_if.sv
`timescale 1ns/1ns
interface mbf_link_if;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_data;
  logic req_last;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;

  modport device (
    input req_valid, req_data, req_last, rsp_ready,
    output req_ready, rsp_valid, rsp_data, rsp_last
  );
  modport master (
    output req_valid, req_data, req_last, rsp_ready,
    input req_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface

//--- logic/mbf_device.sv
`timescale 1ns/1ns
module mbf_device import mbf_pkg::*; #(
  parameter int NUM_REGS = 256,
  parameter int RESP_DELAY = RESP_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  mbf_link_if.device LINK,
  input wire logic [7:0] MY_ADDR,
  output logic WR_STROBE,
  output logic [15:0] WR_ADDR,
  output logic [15:0] WR_DATA,
  output logic [15:0] DIAG_COUNT
);
  typedef enum logic [1:0] {ST_RX, ST_EVAL, ST_WAIT, ST_TX} mbf_dev_state_t;
  localparam int AW = $clog2(NUM_REGS);
  localparam int CW = $clog2(RESP_DELAY + 1);
  localparam logic [16:0] NREG = 17'(NUM_REGS);

  mbf_dev_state_t state;
  logic [15:0] regs [NUM_REGS];
  logic [7:0] hdr [9];
  logic [7:0] idx, slave, fc, hi_byte, exc, chk_exc, bc;
  logic [7:0] tx_idx, tx_len, nidx, next_byte, roff, hl, doff;
  logic [15:0] w0, w1, w2, w3, wbase, radd, rword, diag;
  logic [16:0] waddr;
  logic [CW-1:0] wait_cnt;
  logic take, for_me, bcast, wr_fc, wr_ok, is_read, in_data, data_wr, one_wr;
  logic wait_done, diag_sel;

  // ------------------------------------------------------------
  // Telegram decode
  // ------------------------------------------------------------
  assign w0 = {hdr[0], hdr[1]};
  assign w1 = {hdr[2], hdr[3]};
  assign w2 = {hdr[4], hdr[5]};
  assign w3 = {hdr[6], hdr[7]};
  assign hl = hdr_len(fc);
  assign LINK.req_ready = state == ST_RX;
  assign take = LINK.req_valid && LINK.req_ready;
  assign bcast = slave == BCAST_ADDR;
  assign for_me = slave == MY_ADDR && !bcast;
  assign wr_fc = fc == FC_WR_ONE || fc == FC_WR_MULTI || fc == FC_RW_MULTI;
  assign is_read = fc == FC_RD_HOLD || fc == FC_RD_INPUT || fc == FC_RW_MULTI;
  // Other codes never write, even when broadcast
  assign wr_ok = (for_me || bcast) && wr_fc && chk_exc == EXC_NONE;
  assign doff = idx - 8'h02 - hl;
  assign bc = fc == FC_RW_MULTI ? hdr[8] : hdr[4];
  assign wbase = fc == FC_RW_MULTI ? w2 : w0;
  assign waddr = {1'b0, wbase} + {10'h000, doff[7:1]};
  assign in_data = (fc == FC_WR_MULTI || fc == FC_RW_MULTI) && idx >= 8'h02 + hl && doff < bc;
  assign data_wr = take && wr_ok && in_data && doff[0];
  assign one_wr = take && wr_ok && fc == FC_WR_ONE && idx == 8'h05;

  // Counts and ranges checked before any data byte is stored
  always_comb begin
    chk_exc = EXC_NONE;
    case (fc)
      FC_RD_HOLD, FC_RD_INPUT: begin
        if (w1 == 16'h0000 || w1 > MAX_RD) begin
          chk_exc = EXC_VALUE;
        end else if ({1'b0, w0} + {1'b0, w1} > NREG) begin
          chk_exc = EXC_ADDR;
        end
      end
      FC_WR_ONE: begin
        if ({1'b0, w0} >= NREG) begin
          chk_exc = EXC_ADDR;
        end
      end
      FC_DIAG: begin
        if (w0 != DIAG_ECHO && w0 != DIAG_REG) begin
          chk_exc = EXC_FUNC;
        end
      end
      FC_WR_MULTI: begin
        if (w1 == 16'h0000 || w1 > MAX_WR || hdr[4] != {w1[6:0], 1'b0}) begin
          chk_exc = EXC_VALUE;
        end else if ({1'b0, w0} + {1'b0, w1} > NREG) begin
          chk_exc = EXC_ADDR;
        end
      end
      FC_RW_MULTI: begin
        if (w1 == 16'h0000 || w1 > MAX_RW || w3 == 16'h0000 || w3 > MAX_RW ||
            hdr[8] != {w3[6:0], 1'b0}) begin
          chk_exc = EXC_VALUE;
        end else if ({1'b0, w0} + {1'b0, w1} > NREG ||
                     {1'b0, w2} + {1'b0, w3} > NREG) begin
          chk_exc = EXC_ADDR;
        end
      end
      default: chk_exc = EXC_FUNC;
    endcase
  end

  // ------------------------------------------------------------
  // Receive
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      idx <= 8'h00;
      slave <= 8'h00;
      fc <= 8'h00;
      hi_byte <= 8'h00;
    end else if (take) begin
      if (idx != 8'hFF) begin
        idx <= idx + 8'h01;
      end
      if (idx == 8'h00) begin
        slave <= LINK.req_data;
      end
      if (idx == 8'h01) begin
        fc <= LINK.req_data;
      end
      hi_byte <= LINK.req_data;
    end else if (state == ST_EVAL) begin
      idx <= 8'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < 9; i++) begin
        hdr[i] <= 8'h00;
      end
    end else if (take && idx >= 8'h02 && idx < 8'h0B) begin
      hdr[4'(idx - 8'h02)] <= LINK.req_data;
    end
  end

  // Writes land while the telegram streams in, so a later read sees them
  always_ff @(posedge CLK) begin
    if (one_wr) begin
      regs[w0[AW-1:0]] <= {hdr[2], LINK.req_data};
    end else if (data_wr) begin
      regs[waddr[AW-1:0]] <= {hi_byte, LINK.req_data};
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      WR_STROBE <= 1'b0;
      WR_ADDR <= 16'h0000;
      WR_DATA <= 16'h0000;
    end else begin
      WR_STROBE <= one_wr || data_wr;
      if (one_wr) begin
        WR_ADDR <= w0;
        WR_DATA <= {hdr[2], LINK.req_data};
      end else if (data_wr) begin
        WR_ADDR <= waddr[15:0];
        WR_DATA <= {hi_byte, LINK.req_data};
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  assign wait_done = wait_cnt == CW'(RESP_DELAY - 1);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= ST_RX;
      exc <= EXC_NONE;
    end else begin
      unique case (state)
        ST_RX: begin
          if (take && LINK.req_last) begin
            state <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          exc <= chk_exc;
          // Broadcasts, short and foreign telegrams stay silent
          if (idx < 8'h02 + hl || idx < 8'h02 || !for_me) begin
            state <= ST_RX;
          end else begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (wait_done) begin
            state <= ST_TX;
          end
        end
        ST_TX: begin
          if (LINK.rsp_ready && tx_idx == tx_len - 8'h01) begin
            state <= ST_RX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET || state != ST_WAIT) begin
      wait_cnt <= '0;
    end else begin
      wait_cnt <= wait_cnt + CW'(1);
    end
  end

  // Counts exception replies issued to this address
  always_ff @(posedge CLK) begin
    if (RESET) begin
      diag <= 16'h0000;
    end else if (state == ST_EVAL && for_me && idx >= 8'h02 + hl && chk_exc != EXC_NONE) begin
      diag <= diag + 16'h0001;
    end
  end
  assign DIAG_COUNT = diag;

  // ------------------------------------------------------------
  // Reply
  // ------------------------------------------------------------
  assign tx_len = exc != EXC_NONE ? LEN_EXC :
                  is_read ? LEN_RD_HEAD + {w1[6:0], 1'b0} : LEN_ECHO;
  assign nidx = state == ST_TX ? tx_idx + 8'h01 : 8'h00;
  assign diag_sel = fc == FC_DIAG && w0 == DIAG_REG;

  always_comb begin
    roff = nidx - LEN_RD_HEAD;
    radd = w0 + {9'h000, roff[7:1]};
    rword = regs[radd[AW-1:0]];
    next_byte = slave;
    if (nidx == 8'h00) begin
      next_byte = slave;
    end else if (nidx == 8'h01) begin
      next_byte = exc != EXC_NONE ? (fc | FC_EXC_FLAG) : fc;
    end else if (exc != EXC_NONE) begin
      next_byte = exc;
    end else if (is_read) begin
      if (nidx == 8'h02) begin
        next_byte = {w1[6:0], 1'b0};
      end else begin
        next_byte = roff[0] ? rword[7:0] : rword[15:8];
      end
    end else begin
      unique case (nidx[1:0])
        2'h2: next_byte = hdr[0];
        2'h3: next_byte = hdr[1];
        2'h0: next_byte = diag_sel ? diag[15:8] : hdr[2];
        2'h1: next_byte = diag_sel ? diag[7:0] : hdr[3];
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_data <= 8'h00;
      tx_idx <= 8'h00;
    end else if (state == ST_WAIT && wait_done) begin
      LINK.rsp_valid <= 1'b1;
      LINK.rsp_data <= next_byte;
      tx_idx <= 8'h00;
    end else if (state == ST_TX && LINK.rsp_ready) begin
      if (tx_idx == tx_len - 8'h01) begin
        LINK.rsp_valid <= 1'b0;
      end else begin
        tx_idx <= nidx;
        LINK.rsp_data <= next_byte;
      end
    end
  end
  assign LINK.rsp_last = LINK.rsp_valid && tx_idx == tx_len - 8'h01;
endmodule

//--- logic/mbf_master.sv
`timescale 1ns/1ns
module mbf_master import mbf_pkg::*; #(
  parameter int TIMEOUT = TIMEOUT_CYCLES
) (
  input wire logic CLK,
  input wire logic RESET,
  mbf_link_if.master LINK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_SLAVE,
  input wire logic [7:0] CMD_FC,
  input wire logic [15:0] CMD_W0,
  input wire logic [15:0] CMD_W1,
  input wire logic [15:0] CMD_W2,
  input wire logic [15:0] CMD_W3,
  input wire logic WD_VALID,
  output logic WD_READY,
  input wire logic [15:0] WD_DATA,
  output logic CMD_ERR,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  output logic RSP_LAST,
  output logic DONE,
  output logic TIMED_OUT
);
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} mbf_mst_state_t;
  localparam int TW = $clog2(TIMEOUT + 1);

  mbf_mst_state_t state;
  logic [7:0] slave, fc, hl, nidx, total, doff, lo_byte, next_byte;
  logic [7:0] hb [9];
  logic [TW-1:0] tcnt;
  logic bad, is_bc, cmd_take, can_load, is_hi, load;

  // ------------------------------------------------------------
  // Command check
  // ------------------------------------------------------------
  assign CMD_READY = state == H_IDLE;
  assign cmd_take = CMD_VALID && CMD_READY;
  always_comb begin
    bad = 1'b0;
    case (CMD_FC)
      FC_RD_HOLD, FC_RD_INPUT: bad = CMD_W1 > MAX_RD;
      FC_WR_MULTI: bad = CMD_W1 > MAX_WR;
      FC_RW_MULTI: bad = CMD_W1 > MAX_RW || CMD_W3 > MAX_RW;
      default: bad = 1'b0;
    endcase
    if (CMD_SLAVE == BCAST_ADDR && CMD_FC != FC_WR_ONE && CMD_FC != FC_WR_MULTI &&
        CMD_FC != FC_RW_MULTI) begin
      bad = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Telegram build
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      slave <= 8'h00;
      fc <= 8'h00;
      total <= 8'h00;
      for (int i = 0; i < 9; i++) begin
        hb[i] <= 8'h00;
      end
    end else if (cmd_take && !bad) begin
      slave <= CMD_SLAVE;
      fc <= CMD_FC;
      hb[0] <= CMD_W0[15:8];
      hb[1] <= CMD_W0[7:0];
      hb[2] <= CMD_W1[15:8];
      hb[3] <= CMD_W1[7:0];
      hb[4] <= CMD_FC == FC_RW_MULTI ? CMD_W2[15:8] : {CMD_W1[6:0], 1'b0};
      hb[5] <= CMD_W2[7:0];
      hb[6] <= CMD_W3[15:8];
      hb[7] <= CMD_W3[7:0];
      hb[8] <= {CMD_W3[6:0], 1'b0};
      // Many words go in one telegram, never as repeated single writes
      if (CMD_FC == FC_WR_MULTI) begin
        total <= 8'h02 + HDR_WR_MULTI + {CMD_W1[6:0], 1'b0};
      end else if (CMD_FC == FC_RW_MULTI) begin
        total <= 8'h02 + HDR_RW + {CMD_W3[6:0], 1'b0};
      end else begin
        total <= 8'h02 + hdr_len(CMD_FC);
      end
    end
  end

  assign hl = hdr_len(fc);
  assign doff = nidx - 8'h02 - hl;
  assign is_hi = nidx >= 8'h02 + hl && !doff[0];
  assign can_load = state == H_SEND && (!LINK.req_valid || LINK.req_ready) && nidx < total;
  assign WD_READY = can_load && is_hi;
  assign load = can_load && (!is_hi || WD_VALID);
  assign is_bc = slave == BCAST_ADDR;

  always_comb begin
    if (nidx == 8'h00) begin
      next_byte = slave;
    end else if (nidx == 8'h01) begin
      next_byte = fc;
    end else if (nidx < 8'h02 + hl) begin
      next_byte = hb[4'(nidx - 8'h02)];
    end else if (is_hi) begin
      next_byte = WD_DATA[15:8];
    end else begin
      next_byte = lo_byte;
    end
  end

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= H_IDLE;
      nidx <= 8'h00;
      lo_byte <= 8'h00;
      LINK.req_valid <= 1'b0;
      LINK.req_data <= 8'h00;
      LINK.req_last <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: begin
          nidx <= 8'h00;
          if (cmd_take && !bad) begin
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (load) begin
            LINK.req_valid <= 1'b1;
            LINK.req_data <= next_byte;
            LINK.req_last <= nidx == total - 8'h01;
            nidx <= nidx + 8'h01;
            if (is_hi) begin
              lo_byte <= WD_DATA[7:0];
            end
          end else if (LINK.req_valid && LINK.req_ready) begin
            LINK.req_valid <= 1'b0;
            if (LINK.req_last) begin
              state <= is_bc ? H_IDLE : H_WAIT;
            end
          end
        end
        H_WAIT: begin
          if ((LINK.rsp_valid && LINK.rsp_last) || tcnt == TW'(TIMEOUT - 1)) begin
            state <= H_IDLE;
          end
        end
      endcase
    end
  end

  // Waiting for the first reply byte only; cleared to zero once it shows
  always_ff @(posedge CLK) begin
    if (RESET || state != H_WAIT || LINK.rsp_valid) begin
      tcnt <= '0;
    end else if (tcnt != TW'(TIMEOUT - 1)) begin
      tcnt <= tcnt + TW'(1);
    end
  end

  assign LINK.rsp_ready = state == H_WAIT;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      CMD_ERR <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_DATA <= 8'h00;
      RSP_LAST <= 1'b0;
      DONE <= 1'b0;
      TIMED_OUT <= 1'b0;
    end else begin
      CMD_ERR <= cmd_take && bad;
      RSP_VALID <= state == H_WAIT && LINK.rsp_valid;
      RSP_DATA <= LINK.rsp_data;
      RSP_LAST <= state == H_WAIT && LINK.rsp_valid && LINK.rsp_last;
      DONE <= (state == H_WAIT && LINK.rsp_valid && LINK.rsp_last) ||
              (state == H_SEND && is_bc && LINK.req_valid && LINK.req_ready && LINK.req_last);
      TIMED_OUT <= state == H_WAIT && !LINK.rsp_valid && tcnt == TW'(TIMEOUT - 1);
    end
  end
endmodule

//--- tb/mbf_chk.sv
`timescale 1ns/1ns
module mbf_chk import mbf_pkg::*; #(
  parameter int RESP_DELAY = 20,
  parameter logic [7:0] MY_SLAVE = 8'h11
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  // ----------------------------------------
  // Telegram tracking
  // ----------------------------------------
  localparam int RSP_LO = RESP_DELAY + 1;
  localparam int RSP_HI = RESP_DELAY + 3;
  logic [7:0] req_idx, rsp_idx, hdr_addr, hdr_fc, rsp_fc;
  logic [15:0] hdr_cnt;
  logic silent, req_take, rsp_take, last_take, rd_fc, echo_fc;
  assign req_take = req_valid && req_ready;
  assign rsp_take = rsp_valid && rsp_ready;
  assign last_take = req_take && req_last;
  assign rd_fc = rsp_fc == FC_RD_HOLD || rsp_fc == FC_RD_INPUT || rsp_fc == FC_RW_MULTI;
  assign echo_fc = rsp_fc == FC_WR_ONE || rsp_fc == FC_WR_MULTI || rsp_fc == FC_DIAG;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  always_ff @(posedge CLK) begin
    if (RESET) begin
      req_idx <= 8'h00;
      silent <= 1'b0;
    end else if (req_take) begin
      req_idx <= req_last ? 8'h00 : req_idx + 8'h01;
      silent <= req_last && hdr_addr != MY_SLAVE;
      if (req_idx == 8'h00) hdr_addr <= req_data;
      if (req_idx == 8'h01) hdr_fc <= req_data;
      if (req_idx == 8'h04) hdr_cnt[15:8] <= req_data;
      if (req_idx == 8'h05) hdr_cnt[7:0] <= req_data;
    end
  end
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rsp_idx <= 8'h00;
    end else if (rsp_take) begin
      rsp_idx <= rsp_last ? 8'h00 : rsp_idx + 8'h01;
      if (rsp_idx == 8'h01) rsp_fc <= rsp_data;
    end
  end
  property p_reply_time;
    last_take && hdr_addr == MY_SLAVE |-> ##[RSP_LO:RSP_HI] rsp_valid;
  endproperty
  a_reply_time: assert property (p_reply_time) else $error("reply not on time");
  property p_no_early;
    last_take |=> !rsp_valid [*8];
  endproperty
  a_no_early: assert property (p_no_early) else $error("reply too early");
  property p_silent;
    silent |-> !rsp_valid;
  endproperty
  a_silent: assert property (p_silent) else $error("reply to broadcast");
  property p_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_last);
  endproperty
  a_hold: assert property (p_hold) else $error("reply byte dropped");
  property p_busy;
    last_take && hdr_addr == MY_SLAVE |=> !req_ready [*8];
  endproperty
  a_busy: assert property (p_busy) else $error("request taken during reply");
  property p_addr_first;
    rsp_take && rsp_idx == 8'h00 |-> rsp_data == hdr_addr;
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("wrong reply address");
  property p_fc_echo;
    rsp_take && rsp_idx == 8'h01 |-> rsp_data == hdr_fc || rsp_data == (hdr_fc | FC_EXC_FLAG);
  endproperty
  a_fc_echo: assert property (p_fc_echo) else $error("wrong reply code");
  property p_exc_len;
    rsp_take && rsp_idx == 8'h02 && rsp_fc[7] |-> rsp_last;
  endproperty
  a_exc_len: assert property (p_exc_len) else $error("exception length");
  property p_rd_bytes;
    rsp_take && rsp_idx == 8'h02 && rd_fc |-> rsp_data == {hdr_cnt[6:0], 1'b0};
  endproperty
  a_rd_bytes: assert property (p_rd_bytes) else $error("read byte count");
  property p_rd_len;
    rsp_take && rsp_idx > 8'h01 && rd_fc |-> rsp_last == (rsp_idx == {hdr_cnt[6:0], 1'b0} + 8'h02);
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read reply length");
  property p_echo_len;
    rsp_take && rsp_idx > 8'h01 && echo_fc |-> rsp_last == (rsp_idx == 8'h05);
  endproperty
  a_echo_len: assert property (p_echo_len) else $error("echo reply length");
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top import mbf_pkg::*;;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam logic [7:0] ME = 8'h11;
  logic clk, reset, cmd_valid, cmd_ready, wd_ready, cmd_err, rsp_valid, rsp_last;
  logic done, timed_out, wr_strobe, got_err, got_done, got_to;
  logic wd_valid = 1'b0;
  logic [7:0] cmd_slave, cmd_fc, rsp_data;
  logic [15:0] w0, w1, w2, w3, wr_addr, wr_data, diag_count;
  logic [15:0] wd_data = 16'h0000;
  logic [7:0] rsp_q[$];
  logic [7:0] exp_q[$];
  logic [15:0] wd_q[$];
  logic [31:0] wr_q[$];
  int err_count = 0;
  int checks_done = 0;
  int last_n = 0;
  mbf_link_if link();
  mbf_master #(.TIMEOUT(40)) mbf_master_inst (.CLK(clk), .RESET(reset), .LINK(link.master),
    .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_SLAVE(cmd_slave), .CMD_FC(cmd_fc),
    .CMD_W0(w0), .CMD_W1(w1), .CMD_W2(w2), .CMD_W3(w3), .WD_VALID(wd_valid),
    .WD_READY(wd_ready), .WD_DATA(wd_data), .CMD_ERR(cmd_err), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .RSP_LAST(rsp_last), .DONE(done), .TIMED_OUT(timed_out));
  mbf_device #(.NUM_REGS(256), .RESP_DELAY(20)) mbf_device_inst (.CLK(clk), .RESET(reset),
    .LINK(link.device), .MY_ADDR(ME), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .DIAG_COUNT(diag_count));
  mbf_chk #(.RESP_DELAY(20), .MY_SLAVE(ME)) mbf_chk_inst (.CLK(clk), .RESET(reset),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .req_data(link.req_data),
    .req_last(link.req_last), .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_data(link.rsp_data), .rsp_last(link.rsp_last));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Pulses last one cycle, so the next edge always catches them
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (rsp_last === 1'b1) last_n = rsp_q.size();
    if (wr_strobe === 1'b1) wr_q.push_back({wr_addr, wr_data});
    if (cmd_err === 1'b1) got_err = 1'b1;
    if (done === 1'b1) got_done = 1'b1;
    if (timed_out === 1'b1) got_to = 1'b1;
    if (wd_valid === 1'b1 && wd_ready === 1'b1) void'(wd_q.pop_front());
  end
  always @(negedge clk) begin
    wd_valid <= wd_q.size() > 0;
    wd_data <= wd_q.size() > 0 ? wd_q[0] : 16'h0000;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [7:0] sl, fc, input logic [15:0] a, b, c, d);
    int n;
    @(negedge clk);
    rsp_q.delete();
    wr_q.delete();
    {got_err, got_done, got_to} = 3'b000;
    last_n = 0;
    {cmd_slave, cmd_fc, w0, w1, w2, w3} = {sl, fc, a, b, c, d};
    cmd_valid = 1'b1;
    n = 0;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (!(got_err || got_done || got_to) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (2) @(posedge clk);
    check("finished", n < 3000, 1);
  endtask
  task automatic chk_reply(input string name);
    check({name, " length"}, rsp_q.size(), exp_q.size());
    check({name, " end"}, last_n, exp_q.size());
    for (int i = 0; i < exp_q.size() && i < rsp_q.size(); i++)
      check(name, rsp_q[i], exp_q[i]);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_write_one();
    xfer(ME, FC_WR_ONE, 16'h0002, 16'h1234, 16'h0000, 16'h0000);
    exp_q = '{ME, FC_WR_ONE, 8'h00, 8'h02, 8'h12, 8'h34};
    chk_reply("write one reply");
    check("write one count", wr_q.size(), 1);
    check("write one reg", wr_q[0], 32'h0002_1234);
  endtask
  task automatic t_read_alias();
    logic [7:0] fcs[2] = '{FC_RD_HOLD, FC_RD_INPUT};
    foreach (fcs[i]) begin
      xfer(ME, fcs[i], 16'h0002, 16'h0001, 16'h0000, 16'h0000);
      exp_q = '{ME, fcs[i], 8'h02, 8'h12, 8'h34};
      chk_reply("read alias");
    end
  endtask
  task automatic t_limits();
    for (int i = 0; i < 120; i++) wd_q.push_back(16'h5A00 + 16'(i));
    xfer(ME, FC_WR_MULTI, 16'h0064, 16'h0078, 16'h0000, 16'h0000);
    exp_q = '{ME, FC_WR_MULTI, 8'h00, 8'h64, 8'h00, 8'h78};
    chk_reply("write multi reply");
    check("write multi count", wr_q.size(), 120);
    check("write multi last", wr_q[119], 32'h00DB_5A77);
    xfer(ME, FC_RD_HOLD, 16'h0064, 16'h007D, 16'h0000, 16'h0000);
    check("read max length", rsp_q.size(), 253);
    check("read max bytes", rsp_q[2], 8'hFA);
    for (int i = 0; i < 120; i++)
      check("read max data", {rsp_q[3 + 2 * i], rsp_q[4 + 2 * i]}, 16'h5A00 + 16'(i));
    xfer(ME, FC_RD_HOLD, 16'h0000, 16'h007E, 16'h0000, 16'h0000);
    check("read over limit", got_err, 1'b1);
    xfer(ME, FC_WR_MULTI, 16'h0000, 16'h0079, 16'h0000, 16'h0000);
    check("write over limit", got_err, 1'b1);
    xfer(ME, FC_RW_MULTI, 16'h0000, 16'h0001, 16'h0000, 16'h0077);
    check("combined over limit", got_err, 1'b1);
    xfer(BCAST_ADDR, FC_RD_HOLD, 16'h0000, 16'h0001, 16'h0000, 16'h0000);
    check("broadcast read", got_err, 1'b1);
  endtask
  task automatic t_combined();
    wd_q = '{16'h7777, 16'h8888};
    xfer(ME, FC_RW_MULTI, 16'h0014, 16'h0002, 16'h0014, 16'h0002);
    exp_q = '{ME, FC_RW_MULTI, 8'h04, 8'h77, 8'h77, 8'h88, 8'h88};
    chk_reply("combined reply");
    check("combined writes", wr_q.size(), 2);
  endtask
  task automatic t_exceptions();
    xfer(ME, FC_RD_HOLD, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    exp_q = '{ME, 8'h83, EXC_VALUE};
    chk_reply("zero count");
    xfer(ME, FC_RD_INPUT, 16'h00FA, 16'h000A, 16'h0000, 16'h0000);
    exp_q = '{ME, 8'h84, EXC_ADDR};
    chk_reply("out of range");
    xfer(ME, FC_DIAG, 16'h0005, 16'h0000, 16'h0000, 16'h0000);
    exp_q = '{ME, 8'h88, EXC_FUNC};
    chk_reply("bad sub");
    xfer(ME, 8'h01, 16'h0000, 16'h0001, 16'h0000, 16'h0000);
    exp_q = '{ME, 8'h81, EXC_FUNC};
    chk_reply("bad code");
  endtask
  task automatic t_diag();
    xfer(ME, FC_DIAG, DIAG_ECHO, 16'hBEEF, 16'h0000, 16'h0000);
    exp_q = '{ME, FC_DIAG, 8'h00, 8'h00, 8'hBE, 8'hEF};
    chk_reply("loopback");
    xfer(ME, FC_DIAG, DIAG_REG, 16'h0000, 16'h0000, 16'h0000);
    exp_q = '{ME, FC_DIAG, 8'h00, 8'h02, 8'h00, 8'h04};
    chk_reply("diag register");
    check("diag count", diag_count, 16'h0004);
  endtask
  task automatic t_broadcast();
    // Broadcast gets no reply, so DONE is the only sign of completion
    xfer(BCAST_ADDR, FC_WR_ONE, 16'h0005, 16'h4242, 16'h0000, 16'h0000);
    check("broadcast done", got_done, 1'b1);
    check("broadcast silent", rsp_q.size(), 0);
    check("broadcast write", wr_q.size() > 0 ? wr_q[0] : 32'h0, 32'h0005_4242);
    // Foreign address stays silent, so only the master's timeout ends it
    xfer(8'h22, FC_RD_HOLD, 16'h0000, 16'h0001, 16'h0000, 16'h0000);
    check("foreign timed out", got_to, 1'b1);
    check("foreign silent", rsp_q.size(), 0);
  endtask
  initial begin
    {cmd_valid, cmd_slave, cmd_fc, w0, w1, w2, w3} = '0;
    reset = 1'b1;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    t_write_one();
    t_read_alias();
    t_limits();
    t_combined();
    t_exceptions();
    t_diag();
    t_broadcast();
    end_sim();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule
